/* File: logic/irq_mask_pkg.sv */
// Functional notes
// - Mid mask byte, read/write, resets zero.
// - Mid bit 4 gates reference input thirteen.
// - Mid bits 3..0 gate inputs twelve..nine.
// - Masked-off events never raise an interrupt.
// - High mask byte; bit 7 gates sync alarm.
// - High bit 5 gates phase monitor alarm.
// - High bit 4 gates second-path input failure.
package irq_mask_pkg;

	// Width of the byte address decoded on the register bus.
	localparam int unsigned ADDR_W = 8;
	// Register data width on the bus.
	localparam int unsigned DATA_W = 32;
	// Width of one mask byte.
	localparam int unsigned BYTE_W = 8;
	// Sticky status spans both mask bytes, high byte on top.
	localparam int unsigned STAT_W = 16;

	// Byte addresses of the registers.
	localparam logic [7:0] OFS_MASK_MID  = 8'h44;
	localparam logic [7:0] OFS_MASK_HIGH = 8'h48;
	localparam logic [7:0] OFS_STATUS    = 8'h50;
	localparam logic [7:0] OFS_CLEAR     = 8'h54;
	localparam logic [7:0] OFS_ENABLE    = 8'h58;

	// Reset values.
	localparam logic [7:0]  MASK_RESET   = 8'h00;
	localparam logic [15:0] STAT_RESET   = 16'h0000;
	localparam logic [15:0] ENABLE_RESET = 16'h0000;

	// Bit positions inside the mid mask byte.
	localparam int unsigned REF_NINE_BIT     = 0;
	localparam int unsigned REF_TEN_BIT      = 1;
	localparam int unsigned REF_ELEVEN_BIT   = 2;
	localparam int unsigned REF_TWELVE_BIT   = 3;
	localparam int unsigned REF_THIRTEEN_BIT = 4;

	// Bit positions inside the high mask byte.
	localparam int unsigned SYNC_ALARM_BIT   = 7;
	localparam int unsigned PATH_STATUS_BIT  = 6;
	localparam int unsigned PHASE_ALARM_BIT  = 5;
	localparam int unsigned PATH_FAIL_BIT    = 4;
	localparam int unsigned CODE_VIOL_BIT    = 3;
	localparam int unsigned SIGNAL_LOSS_BIT  = 2;

	// Offset of the high byte inside the status word.
	localparam int unsigned HIGH_BASE = 8;

	// Bus responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Event pulses from the reference inputs nine to thirteen.
	typedef struct packed {
		logic thirteen;
		logic twelve;
		logic eleven;
		logic ten;
		logic nine;
	} ref_events_t;

	// Event pulses from the high-byte sources.
	typedef struct packed {
		logic external_sync_alarm;
		logic second_path_status;
		logic phase_monitor_alarm;
		logic second_path_input_fail;
		logic input_two_coding_violation;
		logic input_two_signal_loss;
	} high_events_t;

	// Write channel states, one-hot.
	typedef enum logic [1:0] {
		WR_COLLECT = 2'h1,
		WR_RESPOND = 2'h2
	} wr_state_t;

	// Read channel states, one-hot.
	typedef enum logic [1:0] {
		RD_IDLE    = 2'h1,
		RD_RESPOND = 2'h2
	} rd_state_t;

endpackage : irq_mask_pkg

/* File: logic/irq_event_latch.sv */
`timescale 1ns/1ns
// Sticky event flags, one per status bit.
module irq_event_latch
(
	input  wire logic                             clk_sys,    // System clock.
	input  wire logic                             srst,       // Synchronous reset.
	input  wire logic [irq_mask_pkg::STAT_W-1:0]  set_req,    // Gated event pulses.
	input  wire logic [irq_mask_pkg::STAT_W-1:0]  clear_req,  // Software clear pulses.
	output logic      [irq_mask_pkg::STAT_W-1:0]  status      // Latched flags.
);

	// Each flag holds until software clears it. A set that lands in the
	// same cycle as the clear wins, so no event is ever dropped.
	for (genvar i = 0; i < irq_mask_pkg::STAT_W; i++)
	begin : g_flag
		always_ff @(posedge clk_sys)
		begin
			if (srst)
			begin
				status[i] <= irq_mask_pkg::STAT_RESET[i];
			end
			else if (set_req[i])
			begin
				status[i] <= 1'b1;
			end
			else if (clear_req[i])
			begin
				status[i] <= 1'b0;
			end
		end
	end

endmodule : irq_event_latch

/* File: logic/interrupt_mask_bits_mid_high.sv */
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns
// Interrupt mask bytes for reference inputs nine to thirteen and the
// high-byte alarm sources, with sticky status behind an AXI4-Lite slave.
module interrupt_mask_bits_mid_high
(
	input  wire logic                               clk_sys,       // System clock.
	input  wire logic                               srst,          // Synchronous reset.
	// Write address channel.
	input  wire logic [irq_mask_pkg::ADDR_W-1:0]    s_axi_awaddr,  // Write byte address.
	input  wire logic                               s_axi_awvalid, // Write address valid.
	output logic                                    s_axi_awready, // Write address taken.
	// Write data channel.
	input  wire logic [irq_mask_pkg::DATA_W-1:0]    s_axi_wdata,   // Write data.
	input  wire logic [3:0]                         s_axi_wstrb,   // Byte enables.
	input  wire logic                               s_axi_wvalid,  // Write data valid.
	output logic                                    s_axi_wready,  // Write data taken.
	// Write response channel.
	output logic [1:0]                              s_axi_bresp,   // Write response.
	output logic                                    s_axi_bvalid,  // Response valid.
	input  wire logic                               s_axi_bready,  // Response taken.
	// Read address channel.
	input  wire logic [irq_mask_pkg::ADDR_W-1:0]    s_axi_araddr,  // Read byte address.
	input  wire logic                               s_axi_arvalid, // Read address valid.
	output logic                                    s_axi_arready, // Read address taken.
	// Read data channel.
	output logic [irq_mask_pkg::DATA_W-1:0]         s_axi_rdata,   // Read data.
	output logic [1:0]                              s_axi_rresp,   // Read response.
	output logic                                    s_axi_rvalid,  // Read data valid.
	input  wire logic                               s_axi_rready,  // Read data taken.
	// Event sources.
	input  wire irq_mask_pkg::ref_events_t          ref_event,     // Reference input events.
	input  wire irq_mask_pkg::high_events_t         high_event,    // High-byte source events.
	// Mask bytes for use elsewhere in the device.
	output logic [irq_mask_pkg::BYTE_W-1:0]         mask_mid,      // Mask bits 15..8.
	output logic [irq_mask_pkg::BYTE_W-1:0]         mask_high,     // Mask bits 23..16.
	// Interrupt request, active high level.
	output logic                                    irq
);

	// Stored mask bytes; the output ports are these flops directly.
	logic [irq_mask_pkg::BYTE_W-1:0] mid_byte;   // Mid mask byte.
	logic [irq_mask_pkg::BYTE_W-1:0] high_byte;  // High mask byte.

	// Interrupt enable over the status layout.
	logic [irq_mask_pkg::STAT_W-1:0] irq_enable;

	// Sticky status and its inputs.
	logic [irq_mask_pkg::STAT_W-1:0] status;     // Latched flags.
	logic [irq_mask_pkg::STAT_W-1:0] raw_event;  // Events in status layout.
	logic [irq_mask_pkg::STAT_W-1:0] gated;      // Events that pass the masks.
	logic [irq_mask_pkg::STAT_W-1:0] clear_req;  // One-cycle clear pulses.

	// Write channel bookkeeping.
	irq_mask_pkg::wr_state_t          wr_state;  // Write channel state.
	logic                            aw_held;   // Address captured.
	logic                            w_held;    // Data captured.
	logic [irq_mask_pkg::ADDR_W-1:0] aw_addr;   // Captured write address.
	logic [irq_mask_pkg::DATA_W-1:0] w_data;    // Captured write data.
	logic                            w_lane0;   // Byte lane zero enabled.
	logic                            w_lane1;   // Byte lane one enabled.
	logic                            wr_fire;   // Both halves present: commit.

	// Read channel bookkeeping.
	irq_mask_pkg::rd_state_t          rd_state;  // Read channel state.
	logic                            ar_fire;   // Read address handshake.

	// Decoded write targets.
	logic                            wr_mid;    // Write hits the mid mask.
	logic                            wr_high;   // Write hits the high mask.
	logic                            wr_clear;  // Write hits the clear register.
	logic                            wr_enable; // Write hits the enable register.
	logic                            wr_known;  // Write address is mapped.

	// Commit happens once both address and data sit in the holding flops.
	assign wr_fire = (wr_state == irq_mask_pkg::WR_COLLECT) && aw_held && w_held;
	assign ar_fire = s_axi_arvalid && s_axi_arready;

	// Address decode of the captured write. Only lane zero carries the
	// byte-wide registers, so a write with that lane off leaves them alone.
	always_comb
	begin
		wr_mid    = (aw_addr == irq_mask_pkg::OFS_MASK_MID);
		wr_high   = (aw_addr == irq_mask_pkg::OFS_MASK_HIGH);
		wr_clear  = (aw_addr == irq_mask_pkg::OFS_CLEAR);
		wr_enable = (aw_addr == irq_mask_pkg::OFS_ENABLE);
		wr_known  = wr_mid || wr_high || wr_clear || wr_enable ||
		            (aw_addr == irq_mask_pkg::OFS_STATUS);
	end

	// Write address capture. The ready drops once an address is held,
	// which throttles the master to one write in flight.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			aw_held       <= 1'b0;
			aw_addr       <= '0;
			s_axi_awready <= 1'b1;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held       <= 1'b1;
			aw_addr       <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		else if (wr_fire)
		begin
			// The address is consumed; ready stays low until the response.
			aw_held <= 1'b0;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_awready <= 1'b1;
		end
	end

	// Write data capture, independent of the address so either may come first.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			w_held       <= 1'b0;
			w_data       <= '0;
			w_lane0      <= 1'b0;
			s_axi_wready <= 1'b1;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held       <= 1'b1;
			w_data       <= s_axi_wdata;
			w_lane0      <= s_axi_wstrb[0];
			s_axi_wready <= 1'b0;
		end
		else if (wr_fire)
		begin
			w_held <= 1'b0;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_wready <= 1'b1;
		end
	end

	// Write channel state and response. Unmapped addresses answer with a
	// slave error and change nothing.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			wr_state     <= irq_mask_pkg::WR_COLLECT;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= irq_mask_pkg::RESP_OKAY;
		end
		else
		begin
			case (wr_state)
				irq_mask_pkg::WR_COLLECT:
				begin
					if (wr_fire)
					begin
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= wr_known ? irq_mask_pkg::RESP_OKAY
						                         : irq_mask_pkg::RESP_SLVERR;
						wr_state     <= irq_mask_pkg::WR_RESPOND;
					end
				end
				irq_mask_pkg::WR_RESPOND:
				begin
					// Hold the response until the master accepts it.
					if (s_axi_bready)
					begin
						s_axi_bvalid <= 1'b0;
						wr_state     <= irq_mask_pkg::WR_COLLECT;
					end
				end
				default:
				begin
					// Recover from an illegal code by dropping back to idle.
					s_axi_bvalid <= 1'b0;
					wr_state     <= irq_mask_pkg::WR_COLLECT;
				end
			endcase
		end
	end

	// Mid mask byte: all eight bits are stored, although only the low five
	// gate sources handled here; the upper three serve other blocks.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			mid_byte <= irq_mask_pkg::MASK_RESET;
		end
		else if (wr_fire && wr_mid && w_lane0)
		begin
			mid_byte <= w_data[irq_mask_pkg::BYTE_W-1:0];
		end
	end

	// High mask byte: bits 1 and 0 are stored for the other AMI input.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			high_byte <= irq_mask_pkg::MASK_RESET;
		end
		else if (wr_fire && wr_high && w_lane0)
		begin
			high_byte <= w_data[irq_mask_pkg::BYTE_W-1:0];
		end
	end

	// Interrupt enable, lanes zero and one cover the sixteen status bits.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			irq_enable <= irq_mask_pkg::ENABLE_RESET;
		end
		else if (wr_fire && wr_enable)
		begin
			if (w_lane0)
			begin
				irq_enable[7:0] <= w_data[7:0];
			end
			if (w_lane1)
			begin
				irq_enable[15:8] <= w_data[15:8];
			end
		end
	end

	// Lane one enable is captured beside lane zero.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			w_lane1 <= 1'b0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_lane1 <= s_axi_wstrb[1];
		end
	end

	// Clear pulses last exactly the commit cycle; write-one-to-clear.
	always_comb
	begin
		clear_req = '0;
		if (wr_fire && wr_clear)
		begin
			clear_req = w_data[irq_mask_pkg::STAT_W-1:0];
		end
	end

	// Place each source on its status bit, matching the mask layout.
	always_comb
	begin
		raw_event = '0;
		raw_event[irq_mask_pkg::REF_NINE_BIT]     = ref_event.nine;
		raw_event[irq_mask_pkg::REF_TEN_BIT]      = ref_event.ten;
		raw_event[irq_mask_pkg::REF_ELEVEN_BIT]   = ref_event.eleven;
		raw_event[irq_mask_pkg::REF_TWELVE_BIT]   = ref_event.twelve;
		raw_event[irq_mask_pkg::REF_THIRTEEN_BIT] = ref_event.thirteen;
		raw_event[irq_mask_pkg::HIGH_BASE + irq_mask_pkg::SYNC_ALARM_BIT] =
			high_event.external_sync_alarm;
		raw_event[irq_mask_pkg::HIGH_BASE + irq_mask_pkg::PATH_STATUS_BIT] =
			high_event.second_path_status;
		raw_event[irq_mask_pkg::HIGH_BASE + irq_mask_pkg::PHASE_ALARM_BIT] =
			high_event.phase_monitor_alarm;
		raw_event[irq_mask_pkg::HIGH_BASE + irq_mask_pkg::PATH_FAIL_BIT] =
			high_event.second_path_input_fail;
		raw_event[irq_mask_pkg::HIGH_BASE + irq_mask_pkg::CODE_VIOL_BIT] =
			high_event.input_two_coding_violation;
		raw_event[irq_mask_pkg::HIGH_BASE + irq_mask_pkg::SIGNAL_LOSS_BIT] =
			high_event.input_two_signal_loss;
	end

	// Gate at the point of capture, not at the output: an event seen while
	// its mask is zero is simply forgotten, so unmasking later cannot
	// resurrect it. The trade-off is that software cannot poll masked events.
	always_comb
	begin
		gated = raw_event & {high_byte, mid_byte};
		// Reference inputs thirteen down to nine follow mid bits 4..0.
		gated[irq_mask_pkg::REF_THIRTEEN_BIT] = raw_event[irq_mask_pkg::REF_THIRTEEN_BIT] &
			mid_byte[irq_mask_pkg::REF_THIRTEEN_BIT];
		gated[irq_mask_pkg::REF_TWELVE_BIT:irq_mask_pkg::REF_NINE_BIT] =
			raw_event[irq_mask_pkg::REF_TWELVE_BIT:irq_mask_pkg::REF_NINE_BIT] &
			mid_byte[irq_mask_pkg::REF_TWELVE_BIT:irq_mask_pkg::REF_NINE_BIT];
		gated[irq_mask_pkg::HIGH_BASE + irq_mask_pkg::SYNC_ALARM_BIT] =
			high_event.external_sync_alarm &
			high_byte[irq_mask_pkg::SYNC_ALARM_BIT];
		gated[irq_mask_pkg::HIGH_BASE + irq_mask_pkg::PHASE_ALARM_BIT] =
			high_event.phase_monitor_alarm &
			high_byte[irq_mask_pkg::PHASE_ALARM_BIT];
		gated[irq_mask_pkg::HIGH_BASE + irq_mask_pkg::PATH_FAIL_BIT] =
			high_event.second_path_input_fail &
			high_byte[irq_mask_pkg::PATH_FAIL_BIT];
		gated[irq_mask_pkg::HIGH_BASE + irq_mask_pkg::PATH_STATUS_BIT] =
			high_event.second_path_status &
			high_byte[irq_mask_pkg::PATH_STATUS_BIT];
		gated[irq_mask_pkg::HIGH_BASE + irq_mask_pkg::CODE_VIOL_BIT] =
			high_event.input_two_coding_violation &
			high_byte[irq_mask_pkg::CODE_VIOL_BIT];
		gated[irq_mask_pkg::HIGH_BASE + irq_mask_pkg::SIGNAL_LOSS_BIT] =
			high_event.input_two_signal_loss &
			high_byte[irq_mask_pkg::SIGNAL_LOSS_BIT];
	end

	// Sticky flags; set wins over a simultaneous clear.
	irq_event_latch u_latch
	(
		.clk_sys   (clk_sys),
		.srst      (srst),
		.set_req   (gated),
		.clear_req (clear_req),
		.status    (status)
	);

	// Interrupt level, registered so the pin is glitch free; it trails the
	// status by one cycle.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			irq <= 1'b0;
		end
		else
		begin
			irq <= |(status & irq_enable);
		end
	end

	// Read channel. One read in flight; data and response held until taken.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			rd_state      <= irq_mask_pkg::RD_IDLE;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= irq_mask_pkg::RESP_OKAY;
		end
		else
		begin
			case (rd_state)
				irq_mask_pkg::RD_IDLE:
				begin
					if (ar_fire)
					begin
						s_axi_arready <= 1'b0;
						s_axi_rvalid  <= 1'b1;
						s_axi_rresp   <= irq_mask_pkg::RESP_OKAY;
						rd_state      <= irq_mask_pkg::RD_RESPOND;
						// Narrow registers sit in the low bits, rest reads zero.
						case (s_axi_araddr)
							irq_mask_pkg::OFS_MASK_MID:  s_axi_rdata <= {24'h000000, mid_byte};
							irq_mask_pkg::OFS_MASK_HIGH: s_axi_rdata <= {24'h000000, high_byte};
							irq_mask_pkg::OFS_STATUS:    s_axi_rdata <= {16'h0000, status};
							irq_mask_pkg::OFS_ENABLE:    s_axi_rdata <= {16'h0000, irq_enable};
							// The clear register is write-only and reads as zero.
							irq_mask_pkg::OFS_CLEAR:     s_axi_rdata <= '0;
							default:
							begin
								s_axi_rdata <= '0;
								s_axi_rresp <= irq_mask_pkg::RESP_SLVERR;
							end
						endcase
					end
				end
				irq_mask_pkg::RD_RESPOND:
				begin
					if (s_axi_rready)
					begin
						s_axi_rvalid  <= 1'b0;
						s_axi_arready <= 1'b1;
						rd_state      <= irq_mask_pkg::RD_IDLE;
					end
				end
				default:
				begin
					s_axi_rvalid  <= 1'b0;
					s_axi_arready <= 1'b1;
					rd_state      <= irq_mask_pkg::RD_IDLE;
				end
			endcase
		end
	end

	// Mask bytes leave the block straight from their flops.
	assign mask_mid  = mid_byte;
	assign mask_high = high_byte;

endmodule : interrupt_mask_bits_mid_high

/* File: verif/irq_mask_monitor.sv */
`timescale 1ns/1ns
// Port-level checks of the mask bytes, the interrupt level and the bus handshakes.
module irq_mask_monitor
(
	input wire logic                               clk_sys,       // System clock.
	input wire logic                               srst,          // Synchronous reset.
	input wire logic                               s_axi_awvalid, // Write address valid.
	input wire logic                               s_axi_awready, // Write address taken.
	input wire logic                               s_axi_wvalid,  // Write data valid.
	input wire logic                               s_axi_wready,  // Write data taken.
	input wire logic                               s_axi_bvalid,  // Write response valid.
	input wire logic                               s_axi_bready,  // Write response taken.
	input wire logic                               s_axi_arvalid, // Read address valid.
	input wire logic                               s_axi_arready, // Read address taken.
	input wire logic                               s_axi_rvalid,  // Read data valid.
	input wire logic                               s_axi_rready,  // Read data taken.
	input wire logic [irq_mask_pkg::DATA_W-1:0]    s_axi_rdata,   // Read data.
	input wire irq_mask_pkg::ref_events_t          ref_event,     // Reference input events.
	input wire irq_mask_pkg::high_events_t         high_event,    // High-byte events.
	input wire logic [irq_mask_pkg::BYTE_W-1:0]    mask_mid,      // Mid mask byte.
	input wire logic [irq_mask_pkg::BYTE_W-1:0]    mask_high,     // High mask byte.
	input wire logic                               irq            // Interrupt level.
);
	default clocking mon_clk @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	// High when some event is let through by its mask bit in this cycle.
	logic gated_hit;
	assign gated_hit = (|(ref_event & mask_mid[4:0])) || (|(high_event & mask_high[7:2]));

	// Both write halves taken at one edge.
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Read address taken.
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	AST_WR_ANSWER: assert property (wr_taken |=> ##1 s_axi_bvalid)
		else $error("write response late");
	AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read data late");
	AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write response not retired");
	AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read data not retired");
	AST_RDATA_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	AST_MID_CHANGE: assert property ($changed(mask_mid) |-> $rose(s_axi_bvalid))
		else $error("mid mask changed without a write");
	AST_HIGH_CHANGE: assert property ($changed(mask_high) |-> $rose(s_axi_bvalid))
		else $error("high mask changed without a write");
	AST_RESET_CLEAR: assert property ($fell(srst) |-> mask_mid == 8'h00 && mask_high == 8'h00 && !irq)
		else $error("state not cleared by reset");
	AST_IRQ_RISE: assert property ($rose(irq) |-> $past(s_axi_bvalid) || $past(gated_hit, 2))
		else $error("interrupt raised by a masked event");
	AST_IRQ_FALL: assert property ($fell(irq) |-> $past(s_axi_bvalid))
		else $error("interrupt dropped without a write");

endmodule : irq_mask_monitor

bind interrupt_mask_bits_mid_high irq_mask_monitor u_irq_mask_monitor
(
	.clk_sys(clk_sys), .srst(srst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.ref_event(ref_event), .high_event(high_event), .mask_mid(mask_mid),
	.mask_high(mask_high), .irq(irq)
);

/* File: verif/test_interrupt_mask_bits_mid_high.sv */
`timescale 1ns/1ns
// Bus-level test of the mask bytes, event gating and the interrupt level.
module test_interrupt_mask_bits_mid_high;
	logic                         clk_sys = 1'b0; // System clock.
	logic                         srst;           // Synchronous reset.
	logic [7:0]                   s_axi_awaddr, s_axi_araddr;
	logic [31:0]                  s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]                   s_axi_wstrb;
	logic [1:0]                   s_axi_bresp, s_axi_rresp, resp;
	logic                         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                         s_axi_rvalid, s_axi_rready, irq;
	irq_mask_pkg::ref_events_t    ref_event;      // Reference input events.
	irq_mask_pkg::high_events_t   high_event;     // High-byte events.
	logic [7:0]                   mask_mid, mask_high, ofs, sel;
	logic [15:0]                  sm;             // Expected status bit.
	int                           mismatches = 0; // Failed comparisons.
	int                           compares = 0;   // All comparisons.

	interrupt_mask_bits_mid_high u_interrupt_mask_bits_mid_high
	(
		.clk_sys(clk_sys), .srst(srst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.ref_event(ref_event), .high_event(high_event), .mask_mid(mask_mid),
		.mask_high(mask_high), .irq(irq)
	);

	// A 4 ns clock.
	always #2 clk_sys = ~clk_sys;

	// Compares one value and reports a difference at once.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report

	// One write; each half is released when taken, and the wait is bounded.
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		logic aw_open;
		logic w_open;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw_open = 1'b1;
		w_open = 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
			if (aw_open && s_axi_awready)
			begin
				s_axi_awvalid <= 1'b0;
				aw_open = 1'b0;
			end
			if (w_open && s_axi_wready)
			begin
				s_axi_wvalid <= 1'b0;
				w_open = 1'b0;
			end
		end
		while ((aw_open || w_open || !s_axi_bvalid) && n < 200);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 200)
			mismatches++;
	endtask : bus_write

	// One read; data and response are taken at the edge that retires them.
	task automatic bus_read(input logic [7:0] a);
		int n;
		logic ar_open;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		ar_open = 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
			if (ar_open && s_axi_arready)
			begin
				s_axi_arvalid <= 1'b0;
				ar_open = 1'b0;
			end
		end
		while ((ar_open || !s_axi_rvalid) && n < 200);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 200)
			mismatches++;
	endtask : bus_read

	// One-cycle event pulse, then time for status and the interrupt to settle.
	task automatic pulse(input logic [4:0] r, input logic [5:0] h);
		@(posedge clk_sys);
		ref_event <= r;
		high_event <= h;
		@(posedge clk_sys);
		ref_event <= 5'h00;
		high_event <= 6'h00;
		repeat (3) @(posedge clk_sys);
	endtask : pulse

	// Cuts a hung run short; the full sequence needs well under 2000 cycles.
	initial
	begin
		repeat (10000) @(posedge clk_sys);
		mismatches++;
		final_report();
	end

	// Main sequence.
	initial
	begin
		srst = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		ref_event = 5'h00;
		high_event = 6'h00;
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		// Reset values of masks and status, and the clear register reading zero.
		foreach (sel[i])
		begin
			if (i < 4)
			begin
				bus_read(8'h44 + 8'(i * 4) + (i > 1 ? 8'h04 : 8'h00));
				check(rd, 32'h00000000);
			end
		end
		check({16'h0000, mask_high, mask_mid}, 32'h00000000);
		// Mask bytes store all eight bits; a cleared low strobe leaves them alone.
		bus_write(8'h44, 32'hFFFFFF5A, 4'hF);
		bus_write(8'h48, 32'h000000A7, 4'hF);
		bus_write(8'h44, 32'h00000000, 4'hE);
		bus_read(8'h44);
		check(rd, 32'h0000005A);
		bus_read(8'h48);
		check(rd, 32'h000000A7);
		check({16'h0000, mask_high, mask_mid}, 32'h0000A75A);
		// Unmapped place: error response and zero data.
		bus_write(8'h60, 32'hFFFFFFFF, 4'hF);
		check({30'h0, resp}, 32'h00000002);
		bus_read(8'h60);
		check({resp, rd[29:0]}, 32'h80000000);
		bus_write(8'h58, 32'h0000FFFF, 4'hF);
		// Each source blocked when its bit is zero, passed when it is one.
		for (int i = 0; i < 11; i++)
		begin
			ofs = (i < 5) ? 8'h44 : 8'h48;
			sel = (i < 5) ? (8'h01 << i) : (8'h04 << (i - 5));
			sm = (i < 5) ? (16'h0001 << i) : (16'h0400 << (i - 5));
			bus_write(ofs, {24'h000000, ~sel}, 4'hF);
			pulse(sm[4:0], sm[15:10]);
			bus_read(8'h50);
			check({rd[30:0], irq}, 32'h00000000);
			bus_write(ofs, {24'h000000, sel}, 4'hF);
			pulse(sm[4:0], sm[15:10]);
			bus_read(8'h50);
			check({rd[31:17], irq, rd[15:0]}, {15'h0000, 1'b1, sm});
			bus_write(8'h54, {16'h0000, sm}, 4'hF);
			bus_read(8'h50);
			check({rd[30:0], irq}, 32'h00000000);
		end
		// A latched event with its enable off keeps the interrupt low until enabled.
		bus_write(8'h58, 32'h00000000, 4'hF);
		bus_write(8'h44, 32'h00000001, 4'hF);
		pulse(5'h01, 6'h00);
		bus_read(8'h50);
		check({rd[30:0], irq}, 32'h00000002);
		bus_write(8'h58, 32'h00000001, 4'hF);
		bus_read(8'h58);
		check({rd[30:0], irq}, 32'h00000003);
		final_report();
	end

endmodule : test_interrupt_mask_bits_mid_high
